// ---- sec_defines.svh ----
// register offsets, field positions, opcodes and reset values of the security engine
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

// register byte offsets on the wishbone slave
`define SEC_ADR_CMD      8'h00
`define SEC_ADR_DATA     8'h04
`define SEC_ADR_STATUS   8'h08
`define SEC_ADR_CTRL     8'h0C
`define SEC_ADR_SECCNT   8'h10

// task-file opcodes
`define SEC_OP_SET_PW    8'hF1
`define SEC_OP_UNLOCK    8'hF2
`define SEC_OP_PREPARE   8'hF3
`define SEC_OP_ERASE     8'hF4
`define SEC_OP_FREEZE    8'hF5
`define SEC_OP_DISABLE   8'hF6

// data sector layout
`define SEC_SECTOR_LAST  8'hFF
`define SEC_PW_WORDS     16
`define SEC_ID_BIT       0
`define SEC_LEVEL_BIT    8

// unlock attempt counter
`define SEC_TRIES        5
`define SEC_CNT_W        3

// status register bit positions
`define SEC_ST_BUSY      0
`define SEC_ST_DRQ       1
`define SEC_ST_ABORT     2
`define SEC_ST_LOCKED    3
`define SEC_ST_FROZEN    4
`define SEC_ST_MAXLVL    5
`define SEC_ST_USERSET   6
`define SEC_ST_PREP      7
`define SEC_ST_CNT_LO    8
`define SEC_ST_EXHAUST   11
`define SEC_ST_SUPP      12

// control register bit positions and reset values
`define SEC_CTRL_SUPP    0
`define SEC_CTRL_RESET   1'b1
`define SEC_SECCNT_RESET 8'h00
`define SEC_SECCNT_FROZE 8'h00

`endif

// ---- sec_pkg.sv ----
// types shared by the security engine and its bench
package sec_pkg;

  // one classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sec_wb_req_type;

  // command sequencer states
  typedef enum logic [1:0] {
    SEC_IDLE,
    SEC_XFER,
    SEC_EXEC
  } sec_state_type;

endpackage : sec_pkg

// ---- sec_engine.sv ----
// ata security command engine with a classic wishbone register slave
// Notes on behaviour
// - abort erase-unit not preceded by erase-prepare
// - erase-unit sector: id bit, 16-word password
// - abort erase-unit on password mismatch
// - freeze-lock sets frozen until hardware reset
// - frozen rejects set, unlock, disable, erase
// - freeze-lock while frozen completes, stays frozen
// - freeze-lock completion zeroes sector count
// - unsupported security runs freeze opcode as wear-level
// - set-password sector: id bit, password words
// - user set stores password, locks after hardware reset
// - high level unlocks by user or master
// - maximum level unlocks by user only
// - master set keeps lock mode and level
// - master unlock at high compares master password
// - master unlock at maximum rejected without compare
// - user unlock compares user password
// - unlock mismatch aborts, decrements counter while locked
// - counter starts five, drops while locked
// - counter zero aborts unlock and erase until reset
// - unlock while unlocked leaves counter alone
// - disable-password match clears lock, keeps master
`timescale 1ns/1ns
`include "sec_defines.svh"

module sec_engine #(
  parameter int PW_WORDS = `SEC_PW_WORDS,
  parameter int TRIES    = `SEC_TRIES
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  hard_reset_i,
  input  wire sec_pkg::sec_wb_req_type wb_req_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  output logic                       erase_start_o,
  output logic                       wear_level_o,
  output logic                       cmd_done_o
);
  import sec_pkg::*;

  // refuse shapes the sector layout or counter cannot hold
  generate
    if (PW_WORDS < 1 || PW_WORDS > 254) begin : g_bad_words
      $error("sec_engine: PW_WORDS out of range");
    end
    // the counter must hold the start value and fit its status field
    if (TRIES < 1 || TRIES >= (1 << `SEC_CNT_W)) begin : g_bad_tries
      $error("sec_engine: TRIES out of range");
    end
    if (`SEC_ST_CNT_LO + `SEC_CNT_W > `SEC_ST_EXHAUST) begin : g_bad_field
      $error("sec_engine: counter field overlaps status bits");
    end
  endgenerate

  localparam logic [`SEC_CNT_W-1:0] TRIES_INIT = `SEC_CNT_W'(TRIES);

  // opcodes that would change the lock mode
  function automatic logic op_guarded(input logic [7:0] op);
    op_guarded = (op == `SEC_OP_SET_PW) || (op == `SEC_OP_UNLOCK) ||
                 (op == `SEC_OP_ERASE) || (op == `SEC_OP_DISABLE);
  endfunction : op_guarded

  // opcodes that use the unlock attempt counter
  function automatic logic op_counted(input logic [7:0] op);
    op_counted = (op == `SEC_OP_UNLOCK) || (op == `SEC_OP_ERASE);
  endfunction : op_counted

  // sequencer and sector capture
  sec_state_type                 state_q;
  sec_state_type                 state_d;
  logic [7:0]                    op_q;
  logic [7:0]                    idx_q;
  logic [15:0]                   ctrlw_q;
  logic                          mis_user_q;
  logic                          mis_master_q;

  // security mode and command result
  logic                          abort_q;
  logic                          locked_q;
  logic                          frozen_q;
  logic                          maxlvl_q;
  logic                          user_set_q;
  logic                          prep_q;
  logic [`SEC_CNT_W-1:0]         cnt_q;
  logic                          supp_q;
  logic [7:0]                    seccnt_q;

  // stored passwords and the sector buffer
  logic [PW_WORDS-1:0][15:0]     user_pw_q;
  logic [PW_WORDS-1:0][15:0]     master_pw_q;
  logic [PW_WORDS-1:0][15:0]     buf_q;

  // bus answer and output pulses
  logic                          ack_q;
  logic [31:0]                   dat_q;
  logic                          erase_q;
  logic                          wear_q;
  logic                          done_q;

  // per-word decode, one bit or word for each password word
  wire logic [PW_WORDS-1:0]       word_hit;
  wire logic [PW_WORDS-1:0]       user_ne;
  wire logic [PW_WORDS-1:0]       master_ne;
  wire logic [PW_WORDS-1:0][15:0] buf_d;

  // bus decode; a request is served once, in the cycle before ack
  wire logic       bus_req   = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  wire logic       bus_wr    = bus_req && wb_req_i.we;
  wire logic       lane0     = wb_req_i.sel[0];
  wire logic       lanes01   = wb_req_i.sel[0] && wb_req_i.sel[1];
  wire logic       cmd_wr    = bus_wr && lane0 && (wb_req_i.adr == `SEC_ADR_CMD);
  wire logic       ctrl_wr   = bus_wr && lane0 && (wb_req_i.adr == `SEC_ADR_CTRL);
  wire logic       scnt_wr   = bus_wr && lane0 && (wb_req_i.adr == `SEC_ADR_SECCNT);
  wire logic       word_wr   = bus_wr && lanes01 && (wb_req_i.adr == `SEC_ADR_DATA) &&
                               (state_q == SEC_XFER);
  wire logic [7:0] new_op    = wb_req_i.dat[7:0];

  // command acceptance, only while idle
  wire logic       start     = cmd_wr && (state_q == SEC_IDLE);
  wire logic       exhausted = (cnt_q == '0);
  wire logic       is_prep   = new_op == `SEC_OP_PREPARE;
  wire logic       is_frz    = new_op == `SEC_OP_FREEZE;
  wire logic       wear_go   = start && !supp_q && is_frz;
  wire logic       rej_frz   = frozen_q && op_guarded(new_op);
  wire logic       rej_prep  = (new_op == `SEC_OP_ERASE) && !prep_q;
  wire logic       rej_cnt   = exhausted && op_counted(new_op);
  wire logic       rej_now   = !supp_q ? !is_frz :
                               (rej_frz || rej_prep || rej_cnt ||
                                !(op_guarded(new_op) || is_prep || is_frz));
  wire logic       needs_data = supp_q && !rej_now && op_guarded(new_op);
  wire logic       quick_ok  = start && !rej_now && !needs_data;

  // the data phase ends with the last word of the sector
  wire logic       last_word = word_wr && (idx_q == `SEC_SECTOR_LAST);

  // execution decisions from the captured sector
  wire logic       id_master = ctrlw_q[`SEC_ID_BIT];
  wire logic       pw_match  = id_master ? !mis_master_q : !mis_user_q;
  wire logic       exec      = state_q == SEC_EXEC;
  wire logic       is_set    = op_q == `SEC_OP_SET_PW;
  wire logic       is_unl    = op_q == `SEC_OP_UNLOCK;
  wire logic       is_ers    = op_q == `SEC_OP_ERASE;
  wire logic       is_dis    = op_q == `SEC_OP_DISABLE;
  wire logic       unl_nocmp = is_unl && id_master && maxlvl_q;
  wire logic       unl_ok    = is_unl && !unl_nocmp && pw_match;
  wire logic       unl_bad   = is_unl && !unl_ok;
  wire logic       ers_ok    = is_ers && pw_match;
  wire logic       dis_ok    = is_dis && pw_match;
  wire logic       exec_ok   = is_set || unl_ok || ers_ok || dis_ok;
  wire logic       cnt_dec   = exec && unl_bad && !unl_nocmp && locked_q &&
                               !exhausted;
  wire logic       clear_lock = exec && (unl_ok || ers_ok || dis_ok);

  // mode events; a hardware reset outranks a command finishing in its cycle
  wire logic       set_user   = exec && is_set && !id_master;
  wire logic       user_clr   = exec && (ers_ok || dis_ok);
  wire logic       frz_go     = start && supp_q && is_frz;

  // completion events: quick commands end at the command write, others after execute
  wire logic       quick_done = start && !needs_data;
  wire logic       ers_go     = exec && ers_ok;

  // per-word capture and compare, so no wide mux sits in the data path
  generate
    for (genvar i = 0; i < PW_WORDS; i++) begin : g_pw
      assign word_hit[i]  = word_wr && (idx_q == 8'(i + 1));
      assign user_ne[i]   = wb_req_i.dat[15:0] != user_pw_q[i];
      assign master_ne[i] = wb_req_i.dat[15:0] != master_pw_q[i];
      assign buf_d[i]     = word_hit[i] ? wb_req_i.dat[15:0] : buf_q[i];
    end
  endgenerate

  // sector buffer; one process owns every word so no two processes share it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      buf_q <= '0;
    end else begin
      buf_q <= buf_d;
    end
  end

  // next sequencer state; a sector is asked for only when the command needs one
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEC_IDLE: state_d = (needs_data && start) ? SEC_XFER : SEC_IDLE;
      SEC_XFER: state_d = last_word ? SEC_EXEC : SEC_XFER;
      SEC_EXEC: state_d = SEC_IDLE;
      default:  state_d = SEC_IDLE;
    endcase
  end

  // sequencer: idle, sector transfer, one execute cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || hard_reset_i) begin
      state_q <= SEC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // word index, control word and running mismatch flags
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      op_q         <= '0;
      idx_q        <= '0;
      ctrlw_q      <= '0;
      mis_user_q   <= 1'b0;
      mis_master_q <= 1'b0;
    end else if (start) begin
      op_q         <= new_op;
      idx_q        <= '0;
      mis_user_q   <= 1'b0;
      mis_master_q <= 1'b0;
    end else if (word_wr) begin
      idx_q        <= idx_q + 8'h01;
      ctrlw_q      <= (idx_q == '0) ? wb_req_i.dat[15:0] : ctrlw_q;
      mis_user_q   <= mis_user_q | (|(word_hit & user_ne));
      mis_master_q <= mis_master_q | (|(word_hit & master_ne));
    end
  end

  // reset_i wipes both passwords; only a hardware reset keeps them
  // password store; reserved words past the password are only counted
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      user_pw_q   <= '0;
      master_pw_q <= '0;
    end else if (exec && is_set) begin
      if (id_master) begin
        master_pw_q <= buf_q;
      end else begin
        user_pw_q   <= buf_q;
      end
    end
  end

  // security mode: user password, level, lock, frozen
  // lock only follows a stored user password at a hardware reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      user_set_q <= 1'b0;
      maxlvl_q   <= 1'b0;
      locked_q   <= 1'b0;
      frozen_q   <= 1'b0;
    end else if (hard_reset_i) begin
      locked_q   <= user_set_q;
      frozen_q   <= 1'b0;
    end else begin
      if (set_user) begin
        user_set_q <= 1'b1;
        maxlvl_q   <= ctrlw_q[`SEC_LEVEL_BIT];
      end else if (user_clr) begin
        user_set_q <= 1'b0;
      end
      if (clear_lock) begin
        locked_q <= 1'b0;
      end
      if (frz_go) begin
        frozen_q <= 1'b1;
      end
    end
  end

  // unlock attempts and the erase-prepare marker
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || hard_reset_i) begin
      cnt_q  <= TRIES_INIT;
      prep_q <= 1'b0;
    end else begin
      if (cnt_dec) begin
        cnt_q <= cnt_q - `SEC_CNT_W'(1);
      end
      if (quick_done) begin
        prep_q <= quick_ok && is_prep;
      end else if (exec) begin
        prep_q <= 1'b0;
      end
    end
  end

  // software-owned control and the sector count register
  // a freeze zeroes the count ahead of a write landing in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      supp_q   <= `SEC_CTRL_RESET;
      seccnt_q <= `SEC_SECCNT_RESET;
    end else begin
      if (ctrl_wr) begin
        supp_q <= wb_req_i.dat[`SEC_CTRL_SUPP];
      end
      if (quick_ok && supp_q && is_frz) begin
        seccnt_q <= `SEC_SECCNT_FROZE;
      end else if (scnt_wr) begin
        seccnt_q <= wb_req_i.dat[7:0];
      end
    end
  end

  // completion pulses and the sticky abort result of the last command
  // pulses last one cycle; the abort flag holds until the next command starts
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      abort_q <= 1'b0;
      done_q  <= 1'b0;
      erase_q <= 1'b0;
      wear_q  <= 1'b0;
    end else begin
      done_q  <= quick_done || exec;
      erase_q <= ers_go;
      wear_q  <= wear_go;
      if (start) begin
        abort_q <= rej_now;
      end else if (exec) begin
        abort_q <= !exec_ok;
      end
    end
  end

  // status word assembled from live state
  logic [31:0] status_word;
  always_comb begin
    status_word                    = '0;
    status_word[`SEC_ST_BUSY]      = state_q != SEC_IDLE;
    status_word[`SEC_ST_DRQ]       = state_q == SEC_XFER;
    status_word[`SEC_ST_ABORT]     = abort_q;
    status_word[`SEC_ST_LOCKED]    = locked_q;
    status_word[`SEC_ST_FROZEN]    = frozen_q;
    status_word[`SEC_ST_MAXLVL]    = maxlvl_q;
    status_word[`SEC_ST_USERSET]   = user_set_q;
    status_word[`SEC_ST_PREP]      = prep_q;
    status_word[`SEC_ST_CNT_LO +: `SEC_CNT_W] = cnt_q;
    status_word[`SEC_ST_EXHAUST]   = exhausted;
    status_word[`SEC_ST_SUPP]      = supp_q;
  end

  // read address decode, kept as named strobes for the mux below
  wire logic       rd_cmd    = wb_req_i.adr == `SEC_ADR_CMD;
  wire logic       rd_stat   = wb_req_i.adr == `SEC_ADR_STATUS;
  wire logic       rd_ctrl   = wb_req_i.adr == `SEC_ADR_CTRL;
  wire logic       rd_scnt   = wb_req_i.adr == `SEC_ADR_SECCNT;

  // read mux; unmapped offsets and the data port read as zero
  wire logic [31:0] rd_word =
    rd_cmd  ? {24'h00_0000, op_q} :
    rd_stat ? status_word :
    rd_ctrl ? {31'h0, supp_q} :
    rd_scnt ? {24'h00_0000, seccnt_q} :
              32'h0000_0000;

  // single-cycle answer; every address is acked so the master never hangs
  // ack falls for a cycle after each answer, so a held strobe is taken only every other cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= bus_req;
      dat_q <= bus_req && !wb_req_i.we ? rd_word : dat_q;
    end
  end

  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = dat_q;
  assign erase_start_o = erase_q;
  assign wear_level_o  = wear_q;
  assign cmd_done_o    = done_q;

endmodule : sec_engine

// ---- sec_engine_props.sv ----
// concurrent checks on the ports of the security engine
`timescale 1ns/1ns
`include "sec_defines.svh"

module sec_engine_props (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    hard_reset_i,
  input  wire sec_pkg::sec_wb_req_type wb_req_i,
  input  wire logic                    wb_ack_o,
  input  wire logic [31:0]             wb_dat_o,
  input  wire logic                    erase_start_o,
  input  wire logic                    wear_level_o,
  input  wire logic                    cmd_done_o
);
  import sec_pkg::*;
  logic [7:0] last_op_q;
  logic       supp_q;
  logic       erase_ok_q;
  // bus decode as the engine sees it
  wire req_take = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire wr_take  = req_take & wb_req_i.we;
  wire cmd_wr   = wr_take & wb_req_i.sel[0] & (wb_req_i.adr == `SEC_ADR_CMD);
  wire ctrl_wr  = wr_take & wb_req_i.sel[0] & (wb_req_i.adr == `SEC_ADR_CTRL);
  wire dat_wr   = wr_take & (wb_req_i.adr == `SEC_ADR_DATA);
  wire f5_wr    = cmd_wr & (wb_req_i.dat[7:0] == `SEC_OP_FREEZE);
  wire f4_wr    = cmd_wr & (wb_req_i.dat[7:0] == `SEC_OP_ERASE);
  wire f5_off   = f5_wr & ~supp_q;
  // shadow of the last opcode; only a supported prepare arms an erase
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || hard_reset_i) begin
      last_op_q  <= 8'h00;
      erase_ok_q <= 1'b0;
    end else if (cmd_wr) begin
      last_op_q  <= supp_q ? wb_req_i.dat[7:0] : 8'h00;
      erase_ok_q <= f4_wr && (last_op_q == `SEC_OP_PREPARE);
    end
  end
  // shadow of the supported flag, kept across hardware reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      supp_q <= `SEC_CTRL_RESET;
    else if (ctrl_wr)
      supp_q <= wb_req_i.dat[`SEC_CTRL_SUPP];
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_freeze_on;
    f5_wr && supp_q;
  endsequence
  sequence s_freeze_off;
    f5_off;
  endsequence

  a_ack_after_take: assert property (req_take |=> wb_ack_o)
    else $error("ack missing one cycle after a request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_freeze_done: assert property (s_freeze_on |=> cmd_done_o && !wear_level_o)
    else $error("freeze did not complete as freeze");
  a_wear_unsupp: assert property (s_freeze_off |=> wear_level_o && cmd_done_o)
    else $error("freeze opcode not run as wear level");
  a_wear_cause: assert property (wear_level_o |-> $past(f5_off))
    else $error("wear level pulse without cause");
  a_erase_prepared: assert property (erase_start_o |-> erase_ok_q)
    else $error("erase started without prepare");
  a_erase_after_data: assert property (erase_start_o |-> $past(dat_wr, 2))
    else $error("erase started without sector");
  a_done_single: assert property (cmd_done_o |=> !cmd_done_o)
    else $error("done pulse too long");
  a_reset_quiet: assert property ($fell(reset_i) |-> !wb_ack_o && !cmd_done_o && !erase_start_o)
    else $error("outputs active right after reset");
endmodule : sec_engine_props

bind sec_engine sec_engine_props u_sec_engine_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .hard_reset_i(hard_reset_i),
  .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .erase_start_o(erase_start_o), .wear_level_o(wear_level_o), .cmd_done_o(cmd_done_o));

// ---- sec_host_model.sv ----
// host controller model: classic wishbone master issuing security commands
`timescale 1ns/1ns
`include "sec_defines.svh"

module sec_host_model (
  input  wire logic                    sys_clk_i,
  input  wire logic                    wb_ack_i,
  input  wire logic [31:0]             wb_dat_i,
  output sec_pkg::sec_wb_req_type      wb_req_o
);
  import sec_pkg::*;
  initial wb_req_o = '0;

  // one classic cycle; released lines show inverted values so stale data never looks valid
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    @(posedge sys_clk_i);
    while (wb_ack_i !== 1'b1) @(posedge sys_clk_i);
    rd = wb_dat_i;
    wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wd};
  endtask : bus

  // opcode, then a sector only while drq is raised, then the final status
  task automatic run(input logic [7:0] op, input logic [15:0] w0, input logic [7:0] key,
                     output logic [31:0] st);
    logic [31:0] rd;
    logic [15:0] w;
    bus(1'b1, `SEC_ADR_CMD, {24'h0, op}, rd);
    bus(1'b0, `SEC_ADR_STATUS, 32'h0, st);
    if (st[`SEC_ST_DRQ] === 1'b1) begin
      for (int i = 0; i < 256; i++) begin
        w = (i == 0) ? w0 : {key, 8'(i)};
        bus(1'b1, `SEC_ADR_DATA, {~w, w}, rd);
      end
    end
    bus(1'b0, `SEC_ADR_STATUS, 32'h0, st);
  endtask : run
endmodule : sec_host_model

// ---- sec_engine_tb.sv ----
// self-checking bench for the security engine
`timescale 1ns/1ns
`include "sec_defines.svh"

module sec_engine_tb;
  import sec_pkg::*;
  logic           sys_clk_i = 1'b0;
  logic           reset_i = 1'b1;
  logic           hard_reset_i = 1'b0;
  sec_wb_req_type wb_req;
  logic           wb_ack, erase_start, wear_level, cmd_done;
  logic [31:0]    wb_dat, st, rd;
  logic [15:0]    seed = 16'h000E;
  logic [7:0]     ku, km;
  int             err_total = 0, cmp_count = 0, n_erase = 0, n_wear = 0, cycles = 0;
  int             n_done = 0;
  localparam logic [7:0] LOCK_OPS [4] = '{`SEC_OP_SET_PW, `SEC_OP_UNLOCK, `SEC_OP_DISABLE,
                                          `SEC_OP_ERASE};

  always #4 sys_clk_i = ~sys_clk_i;

  sec_engine u_sec_engine (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .hard_reset_i(hard_reset_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat),
    .erase_start_o(erase_start), .wear_level_o(wear_level), .cmd_done_o(cmd_done));
  sec_host_model u_sec_host_model (.sys_clk_i(sys_clk_i), .wb_ack_i(wb_ack),
    .wb_dat_i(wb_dat), .wb_req_o(wb_req));

  // pulse counters sampled mid-cycle, and a ceiling well above the expected run
  always @(negedge sys_clk_i) begin
    if (erase_start === 1'b1) n_erase++;
    if (wear_level === 1'b1) n_wear++;
    if (cmd_done === 1'b1) n_done++;
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // control word with random reserved bits 15:9
  function automatic logic [15:0] ctl(input logic id, input logic lvl);
    seed = lfsr(seed);
    return {seed[6:0], lvl, 7'h00, id};
  endfunction : ctl
  function automatic logic [31:0] exp_st(input logic ab, lk, fz, input logic [2:0] cnt);
    return {20'h0, cnt == 3'd0, cnt, 3'h0, fz, lk, ab, 2'h0};
  endfunction : exp_st

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_st(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if ((got & 32'h0000_0F1C) !== exp) begin
      err_total++;
      $display("wrong value at %0t: status %h expected %h", $time, got, exp);
    end
  endtask : chk_st
  task automatic step(input logic [7:0] op, input logic pre, input logic [15:0] w,
                      input logic [7:0] k, input logic [31:0] exp);
    int d0;
    d0 = n_done;
    if (pre) u_sec_host_model.run(`SEC_OP_PREPARE, 16'h0000, 8'h00, st);
    u_sec_host_model.run(op, w, k, st);
    chk_st(st, exp);
    chk_val(32'(n_done - d0), pre ? 32'd2 : 32'd1);
  endtask : step
  task automatic hrst();
    @(posedge sys_clk_i);
    hard_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    hard_reset_i <= 1'b0;
  endtask : hrst
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // main sequence; expectations follow the security state worked out by hand
  initial begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    seed = lfsr(seed);
    ku = seed[7:0];
    km = ~ku;
    u_sec_host_model.bus(1'b0, `SEC_ADR_STATUS, 32'h0, rd);
    chk_val(rd, 32'h0000_1500);
    u_sec_host_model.bus(1'b0, `SEC_ADR_CTRL, 32'h0, rd);
    chk_val(rd, 32'h0000_0001);
    u_sec_host_model.bus(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
    u_sec_host_model.bus(1'b0, 8'h20, 32'h0, rd);
    chk_val(rd, 32'h0000_0000);
    step(`SEC_OP_ERASE, 1'b0, ctl(1, 0), km, exp_st(1, 0, 0, 5));
    step(`SEC_OP_SET_PW, 1'b0, ctl(1, 0), km, exp_st(0, 0, 0, 5));
    step(`SEC_OP_SET_PW, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 0, 5));
    hrst();
    step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku ^ 8'h01, exp_st(1, 1, 0, 4));
    step(`SEC_OP_UNLOCK, 1'b0, ctl(1, 0), km, exp_st(0, 0, 0, 4));
    step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku ^ 8'h01, exp_st(1, 0, 0, 4));
    step(`SEC_OP_ERASE, 1'b1, ctl(1, 0), ku ^ 8'h01, exp_st(1, 0, 0, 4));
    step(`SEC_OP_ERASE, 1'b1, ctl(1, 0), km, exp_st(0, 0, 0, 4));
    chk_val(32'(n_erase), 32'd1);
    step(`SEC_OP_SET_PW, 1'b0, ctl(0, 1), ku, exp_st(0, 0, 0, 4));
    chk_val({31'h0, st[`SEC_ST_MAXLVL]}, 32'd1);
    hrst();
    step(`SEC_OP_UNLOCK, 1'b0, ctl(1, 0), km, exp_st(1, 1, 0, 5));
    step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 0, 5));
    hrst();
    step(`SEC_OP_DISABLE, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 0, 5));
    step(`SEC_OP_SET_PW, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 0, 5));
    hrst();
    step(`SEC_OP_UNLOCK, 1'b0, ctl(1, 0), km, exp_st(0, 0, 0, 5));
    hrst();
    for (int i = 4; i >= 0; i--) begin
      step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku ^ 8'h80, exp_st(1, 1, 0, 3'(i)));
    end
    step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku, exp_st(1, 1, 0, 0));
    step(`SEC_OP_ERASE, 1'b1, ctl(1, 0), km, exp_st(1, 1, 0, 0));
    hrst();
    step(`SEC_OP_UNLOCK, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 0, 5));
    u_sec_host_model.bus(1'b1, `SEC_ADR_SECCNT, 32'h0000_005A, rd);
    step(`SEC_OP_FREEZE, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 1, 5));
    u_sec_host_model.bus(1'b0, `SEC_ADR_SECCNT, 32'h0, rd);
    chk_val(rd, 32'h0000_0000);
    step(`SEC_OP_FREEZE, 1'b0, ctl(0, 0), ku, exp_st(0, 0, 1, 5));
    foreach (LOCK_OPS[j]) begin
      step(LOCK_OPS[j], j == 3, ctl(0, 0), ku, exp_st(1, 0, 1, 5));
    end
    hrst();
    u_sec_host_model.bus(1'b1, `SEC_ADR_CTRL, 32'h0, rd);
    step(`SEC_OP_FREEZE, 1'b0, ctl(0, 0), ku, exp_st(0, 1, 0, 5));
    chk_val(32'(n_wear), 32'd1);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    u_sec_host_model.bus(1'b0, `SEC_ADR_STATUS, 32'h0, rd);
    chk_val(rd, 32'h0000_1500);
    tally_and_finish();
  end
endmodule : sec_engine_tb
